// file: inc/clk_sel_defines.svh
// register offsets, field positions, reset values and timing counts
// for the internal clock and pll select block; definitions only
`ifndef CLK_SEL_DEFINES_SVH
`define CLK_SEL_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define OFS_OSC_CONTROL   8'h00
`define OFS_OSC_STATUS    8'h01
`define OFS_OSC_AUX       8'h02

// ****************************************
// osc_control_reg and aux register fields
// ****************************************
`define CTL_SPLL_BIT      7
`define CTL_IFS_HI        6
`define CTL_IFS_LO        3
`define CTL_SYS_SEL_HI    1
`define CTL_SYS_SEL_LO    0
`define AUX_TOSC_BIT      0

// ****************************************
// oscillator_status fields
// ****************************************
`define ST_SOSC_RDY       7
`define ST_PLL_RDY        6
`define ST_STARTUP        5
`define ST_HF_RDY         4
`define ST_HF_LOCKED      3
`define ST_MF_RDY         2
`define ST_LF_RDY         1
`define ST_HF_STABLE      0

// ****************************************
// field codes and reset values
// ****************************************
`define IFS_RESET         4'h7
`define IFS_8MHZ          4'hE
`define IFS_LF_LIMIT      4'h2
`define IFS_HF_ALT        4'h3
`define SYS_SEL_CONFIG    2'h0
`define SYS_SEL_SECONDARY 2'h1
`define CFG_OSC_INTERNAL  3'h4
`define BYTE_ZERO         8'h00

// ****************************************
// timing, in ns, and derived cycle counts
// ****************************************
`define CLK_PERIOD_NS     8
`define PLL_LOCK_NS       2000
`define HF_LOCK_NS        1000
`define HF_STABLE_NS      4000
`define NS_TO_CYC(t)      (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_LOCK_CYC      `NS_TO_CYC(`PLL_LOCK_NS)
`define HF_LOCK_CYC       `NS_TO_CYC(`HF_LOCK_NS)
`define HF_STABLE_CYC     `NS_TO_CYC(`HF_STABLE_NS)

`endif

// file: inc/clk_sel_pkg.sv
// types shared by the clock select block
// needs nothing from its surroundings
package clk_sel_pkg;

  // ****************************************
  // system clock source, one-hot
  // ****************************************
  typedef enum logic [2:0] {
    SRC_CONFIG    = 3'b001,
    SRC_SECONDARY = 3'b010,
    SRC_INTERNAL  = 3'b100
  } osc_src_t;

  // ****************************************
  // internal oscillator behind the mux, one-hot
  // ****************************************
  typedef enum logic [2:0] {
    PICK_LF = 3'b001,
    PICK_MF = 3'b010,
    PICK_HF = 3'b100
  } int_osc_t;

endpackage

// file: rtl/ready_timer.sv
// delay timer: flags done once its enable has held for CYCLES clocks
// assumes a synchronous active-low reset and one clock
`timescale 1ns/1ns

module ready_timer
#(
  parameter int CYCLES = 16
)
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      done_r
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         done_nxt;

  // dropping the enable restarts the wait from zero
  always_comb
  begin
    cnt_nxt  = cnt_r;
    done_nxt = done_r;
    if (!run)
    begin
      cnt_nxt  = '0;
      done_nxt = 1'b0;
    end
    else if (!done_r)
    begin
      if (cnt_r == LAST)
        done_nxt = 1'b1;
      else
        cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

endmodule

// file: rtl/internal_clock_pll_select.sv
// system clock source select with 4x pll enable and oscillator status
// assumes one 125 MHz clock, synchronous active-low reset, and
// oscillator running levels already synchronous to mclk
//
// Summary of operation
// [R01] 32 MHz clock: internal oscillator output through the 4x pll.
// [R02] configuration select 100 picks the internal oscillator as source.
// [R03] runtime select 00 uses the clock the configuration select names.
// [R04] frequency select 1110 feeds the 8 MHz oscillator output to the pll.
// [R05] pll runs when software enable or configuration enable is set.
// [R06] configuration enable forces pll on; software enable then has no effect.
// [R07] runtime select 1x keeps the pll off the internal oscillator path.
// [R08] read-only 8-bit status: ready, lock, stable and start-up flags.
// [R09] secondary ready follows oscillator when enabled, else reads 1.
// [R10] locked at 2 percent, stable at 0.5 percent, start-up shows source.
// [R11] any reset loads frequency select with 0111, 500 kHz.
// [R12] mux picks among high, medium and low frequency internal oscillators.
`timescale 1ns/1ns
`include "clk_sel_defines.svh"

module internal_clock_pll_select
  import clk_sel_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data_r,
  input  wire logic [2:0] cfg_osc_select,
  input  wire logic       cfg_pll_enable,
  input  wire logic       sec_osc_running,
  input  wire logic       hf_osc_running,
  input  wire logic       mf_osc_running,
  input  wire logic       lf_osc_running,
  output osc_src_t        src_sel_r,
  output int_osc_t        int_osc_pick_r,
  output logic      [3:0] int_freq_code_r,
  output logic            pll_on_r,
  output logic            pll_in_path_r,
  output logic            clk_32m_r
);

  // ****************************************
  // software registers
  // ****************************************
  logic       sw_pll_enable_r;
  logic [3:0] int_freq_select_r;
  logic [1:0] sys_clk_select_r;
  logic       timer_osc_enable_r;
  logic       sw_pll_enable_nxt;
  logic [3:0] int_freq_select_nxt;
  logic [1:0] sys_clk_select_nxt;
  logic       timer_osc_enable_nxt;
  logic [7:0] rd_data_nxt;
  logic [7:0] oscillator_status;
  logic [7:0] ctl_view;

  always_comb
  begin
    sw_pll_enable_nxt    = sw_pll_enable_r;
    int_freq_select_nxt  = int_freq_select_r;
    sys_clk_select_nxt   = sys_clk_select_r;
    timer_osc_enable_nxt = timer_osc_enable_r;
    if (wr_en && addr == `OFS_OSC_CONTROL)
    begin
      sw_pll_enable_nxt   = wr_data[`CTL_SPLL_BIT];
      int_freq_select_nxt = wr_data[`CTL_IFS_HI:`CTL_IFS_LO];
      sys_clk_select_nxt  = wr_data[`CTL_SYS_SEL_HI:`CTL_SYS_SEL_LO];
    end
    if (wr_en && addr == `OFS_OSC_AUX)
      timer_osc_enable_nxt = wr_data[`AUX_TOSC_BIT];
  end

  // status writes are dropped: the register is read-only
  always_comb
  begin
    ctl_view = `BYTE_ZERO;
    ctl_view[`CTL_SPLL_BIT]           = sw_pll_enable_r;
    ctl_view[`CTL_IFS_HI:`CTL_IFS_LO] = int_freq_select_r;
    ctl_view[`CTL_SYS_SEL_HI:`CTL_SYS_SEL_LO] = sys_clk_select_r;
    rd_data_nxt = `BYTE_ZERO;
    if (rd_en)
    begin
      unique case (addr)
        `OFS_OSC_CONTROL: rd_data_nxt = ctl_view;
        `OFS_OSC_STATUS:  rd_data_nxt = oscillator_status; // R08
        `OFS_OSC_AUX:     rd_data_nxt = {7'h00, timer_osc_enable_r};
        default:          rd_data_nxt = `BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sw_pll_enable_r    <= 1'b0;
      int_freq_select_r  <= `IFS_RESET; // R11
      sys_clk_select_r   <= `SYS_SEL_CONFIG;
      timer_osc_enable_r <= 1'b0;
      rd_data_r          <= `BYTE_ZERO;
    end
    else
    begin
      sw_pll_enable_r    <= sw_pll_enable_nxt;
      int_freq_select_r  <= int_freq_select_nxt;
      sys_clk_select_r   <= sys_clk_select_nxt;
      timer_osc_enable_r <= timer_osc_enable_nxt;
      rd_data_r          <= rd_data_nxt;
    end
  end

  // ****************************************
  // source select and pll control
  // ****************************************
  osc_src_t   src_nxt;
  int_osc_t   pick_nxt;
  logic       pll_on_nxt;
  logic       path_nxt;
  logic       fast_nxt;
  logic       pll_rdy;
  logic       hf_locked;
  logic       hf_stable;

  always_comb
  begin
    // runtime select 00 defers to the configuration word
    if (sys_clk_select_r == `SYS_SEL_CONFIG)                       // R03
      src_nxt = (cfg_osc_select == `CFG_OSC_INTERNAL) ? SRC_INTERNAL // R02
                                                      : SRC_CONFIG;
    else if (sys_clk_select_r == `SYS_SEL_SECONDARY)
      src_nxt = SRC_SECONDARY;
    else
      src_nxt = SRC_INTERNAL;
    // duplicate codes trade power against switch time
    if (int_freq_select_r < `IFS_LF_LIMIT)                         // R12
      pick_nxt = PICK_LF;
    else if (int_freq_select_r[3] || int_freq_select_r == `IFS_HF_ALT)
      pick_nxt = PICK_HF;
    else
      pick_nxt = PICK_MF;
    // configuration enable cannot be overridden by software
    pll_on_nxt = cfg_pll_enable | sw_pll_enable_r;                 // R05 R06
    // pll only multiplies the internal oscillator under select 00
    path_nxt = pll_on_nxt && (sys_clk_select_r == `SYS_SEL_CONFIG);  // R07
    fast_nxt = path_nxt && src_nxt == SRC_INTERNAL                 // R01
               && int_freq_select_r == `IFS_8MHZ && pll_rdy;       // R04
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      src_sel_r       <= SRC_CONFIG;
      int_osc_pick_r  <= PICK_MF;
      int_freq_code_r <= `IFS_RESET;
      pll_on_r        <= 1'b0;
      pll_in_path_r   <= 1'b0;
      clk_32m_r       <= 1'b0;
    end
    else
    begin
      src_sel_r       <= src_nxt;
      int_osc_pick_r  <= pick_nxt;
      int_freq_code_r <= int_freq_select_r;
      pll_on_r        <= pll_on_nxt;
      pll_in_path_r   <= path_nxt;
      clk_32m_r       <= fast_nxt;
    end
  end

  // ****************************************
  // ready and accuracy timers
  // ****************************************
  ready_timer #(.CYCLES(`PLL_LOCK_CYC)) u_pll_timer
  (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .run    (pll_on_r),
    .done_r (pll_rdy)
  );

  ready_timer #(.CYCLES(`HF_LOCK_CYC)) u_hf_lock_timer
  (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .run    (hf_osc_running),
    .done_r (hf_locked)
  );

  ready_timer #(.CYCLES(`HF_STABLE_CYC)) u_hf_stable_timer
  (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .run    (hf_osc_running),
    .done_r (hf_stable)
  );

  always_comb
  begin
    oscillator_status = `BYTE_ZERO;
    oscillator_status[`ST_SOSC_RDY]  = timer_osc_enable_r ? sec_osc_running
                                                          : 1'b1;  // R09
    oscillator_status[`ST_PLL_RDY]   = pll_rdy;
    oscillator_status[`ST_STARTUP]   = (src_sel_r == SRC_CONFIG);  // R10
    oscillator_status[`ST_HF_RDY]    = hf_osc_running;
    oscillator_status[`ST_HF_LOCKED] = hf_locked;                  // R10
    oscillator_status[`ST_MF_RDY]    = mf_osc_running;
    oscillator_status[`ST_LF_RDY]    = lf_osc_running;
    oscillator_status[`ST_HF_STABLE] = hf_stable;                  // R10
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence seq_rd_status;
    rd_en && addr == `OFS_OSC_STATUS;
  endsequence

  sequence seq_hf_lost;
    !hf_osc_running ##1 1'b1;
  endsequence

  pll_forced_a : assert property (cfg_pll_enable |=> pll_on_r) // R06
    else $error("pll off while configuration enable set");
  pll_enable_a : assert property (
    !cfg_pll_enable && !sw_pll_enable_r |=> !pll_on_r) // R05
    else $error("pll on with both enables clear");
  pll_path_a : assert property (
    sys_clk_select_r[1] |=> !pll_in_path_r) // R07
    else $error("pll in path while runtime select is 1x");
  ifs_reset_a : assert property (
    $rose(rst_b) |-> int_freq_select_r == `IFS_RESET) // R11
    else $error("frequency select not at reset value");
  clk_fast_a : assert property (clk_32m_r |-> $past(pll_rdy)
    && $past(int_freq_select_r) == `IFS_8MHZ
    && $past(sys_clk_select_r) == `SYS_SEL_CONFIG
    && $past(cfg_osc_select) == `CFG_OSC_INTERNAL) // R01
    else $error("32 MHz flagged without its settings");
  sosc_ready_a : assert property (
    seq_rd_status ##0 !timer_osc_enable_r |=> rd_data_r[`ST_SOSC_RDY]) // R09
    else $error("secondary ready not 1 while disabled");
  status_read_a : assert property (
    seq_rd_status |=> rd_data_r == $past(oscillator_status)) // R08
    else $error("status read data mismatch");
  hf_lock_drop_a : assert property (seq_hf_lost |-> !hf_locked && !hf_stable) // R10
    else $error("accuracy flag held after oscillator stopped");
  mux_lf_a : assert property (
    int_freq_select_r < `IFS_LF_LIMIT |=> int_osc_pick_r == PICK_LF) // R12
    else $error("low range code did not pick low oscillator");

endmodule

// file: verification/internal_clock_pll_select_tb.sv
// self-checking bench for the clock source and pll select block
// assumes the design package and the register map header are compiled
`timescale 1ns/1ns
`include "clk_sel_defines.svh"

module internal_clock_pll_select_tb
  import clk_sel_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  rd_data_r;
  logic [2:0]  cfg_osc_select = 3'h2;
  logic        cfg_pll_enable = 1'b0;
  logic        sec_osc_running = 1'b0;
  logic        hf_osc_running = 1'b0;
  logic        mf_osc_running = 1'b0;
  logic        lf_osc_running = 1'b0;
  osc_src_t    src_sel_r;
  int_osc_t    int_osc_pick_r;
  logic [3:0]  int_freq_code_r;
  logic        pll_on_r;
  logic        pll_in_path_r;
  logic        clk_32m_r;
  logic [31:0] seed = 32'h31a2_5af5;
  logic [7:0]  d;
  logic [7:0]  v;
  int          num_errors = 0;
  int          num_checks = 0;

  always #4 mclk = ~mclk;

  internal_clock_pll_select internal_clock_pll_select_inst (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data_r(rd_data_r),
    .cfg_osc_select(cfg_osc_select), .cfg_pll_enable(cfg_pll_enable),
    .sec_osc_running(sec_osc_running), .hf_osc_running(hf_osc_running),
    .mf_osc_running(mf_osc_running), .lf_osc_running(lf_osc_running),
    .src_sel_r(src_sel_r), .int_osc_pick_r(int_osc_pick_r),
    .int_freq_code_r(int_freq_code_r), .pll_on_r(pll_on_r),
    .pll_in_path_r(pll_in_path_r), .clk_32m_r(clk_32m_r)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  // duplicate codes: 1xxx and 0011 both land on the fast oscillator
  function automatic logic [2:0] exp_pick(input logic [3:0] c);
    if (c[3] || c == 4'h3)
    begin
      return PICK_HF;
    end
    return (c < `IFS_LF_LIMIT) ? PICK_LF : PICK_MF;
  endfunction

  function automatic logic [2:0] exp_src(input logic [1:0] s);
    if (s == `SYS_SEL_CONFIG)
    begin
      return SRC_CONFIG;
    end
    return (s == `SYS_SEL_SECONDARY) ? SRC_SECONDARY : SRC_INTERNAL;
  endfunction

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk);
    addr    <= a;
    wr_data <= x;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 x = rd_data_r;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    #160000;
    num_errors++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    wt(1);
    rd(`OFS_OSC_CONTROL, d);
    chk("ctl reset", 8'h38, d);
    chk("code reset", 8'h07, {4'h0, int_freq_code_r});
    chk("pick reset", 8'(PICK_MF), 8'(int_osc_pick_r));
    rd(`OFS_OSC_AUX, d);
    chk("aux reset", 8'h00, d);
    rd(`OFS_OSC_STATUS, d);
    chk("status reset", 8'hA0, d);
    rd(8'h7F, d);
    chk("unmapped", 8'h00, d);
    $display("test reset done");

    repeat (12)
    begin
      seed = lfsr(seed);
      v = seed[7:0];
      wr(`OFS_OSC_CONTROL, v);
      wr(`OFS_OSC_STATUS, ~v);
      rd(`OFS_OSC_CONTROL, d);
      chk("ctl rw", v & 8'hFB, d);
      chk("code", {4'h0, v[6:3]}, {4'h0, int_freq_code_r});
      chk("pick", 8'(exp_pick(v[6:3])), 8'(int_osc_pick_r));
      chk("src", 8'(exp_src(v[1:0])), 8'(src_sel_r));
      chk("pll on", 8'(v[7]), 8'(pll_on_r));
      chk("pll path", 8'(v[7] && !v[1:0]), 8'(pll_in_path_r));
    end
    // lowest frequency code 0001, which the random codes may never reach
    wr(`OFS_OSC_CONTROL, 8'h08);
    wt(3);
    chk("pick lf", 8'(PICK_LF), 8'(int_osc_pick_r));
    $display("test registers done");

    // configuration enable overrides a cleared software bit
    cfg_pll_enable <= 1'b1;
    wr(`OFS_OSC_CONTROL, 8'h70);
    wt(3);
    chk("cfg force", 8'h01, 8'(pll_on_r));
    chk("cfg path", 8'h01, 8'(pll_in_path_r));
    wr(`OFS_OSC_CONTROL, 8'h72);
    wt(3);
    chk("sel 1x path", 8'h00, 8'(pll_in_path_r));
    chk("sel 1x on", 8'h01, 8'(pll_on_r));
    cfg_pll_enable <= 1'b0;
    wr(`OFS_OSC_CONTROL, 8'h38);
    wt(4);
    chk("pll off", 8'h00, 8'(pll_on_r));
    $display("test pll enable done");

    cfg_osc_select <= `CFG_OSC_INTERNAL;
    wr(`OFS_OSC_CONTROL, 8'hF0);
    wt(3);
    chk("path 32m", 8'h01, 8'(pll_in_path_r));
    chk("pick 8m", 8'(PICK_HF), 8'(int_osc_pick_r));
    wt(240);
    chk("clk early", 8'h00, 8'(clk_32m_r));
    wt(20);
    chk("clk 32m", 8'h01, 8'(clk_32m_r));
    rd(`OFS_OSC_STATUS, d);
    chk("pll ready", 8'h01, 8'(d[`ST_PLL_RDY]));
    wr(`OFS_OSC_CONTROL, 8'hF1);
    wt(3);
    chk("clk sel 01", 8'h00, 8'(clk_32m_r));
    wr(`OFS_OSC_CONTROL, 8'hF0);
    cfg_osc_select <= 3'h2;
    wt(4);
    chk("clk cfg sel", 8'h00, 8'(clk_32m_r));
    $display("test 32 MHz done");

    wr(`OFS_OSC_CONTROL, 8'h3A);
    wr(`OFS_OSC_AUX, 8'h01);
    seed = lfsr(seed);
    mf_osc_running <= seed[0];
    lf_osc_running <= seed[1];
    rd(`OFS_OSC_STATUS, d);
    chk("status sec off", {5'h00, seed[0], seed[1], 1'b0}, d);
    sec_osc_running <= 1'b1;
    hf_osc_running  <= 1'b1;
    wt(100);
    rd(`OFS_OSC_STATUS, d);
    chk("hf early", {4'h9, 1'b0, seed[0], seed[1], 1'b0}, d);
    wt(40);
    rd(`OFS_OSC_STATUS, d);
    chk("hf locked", {4'h9, 1'b1, seed[0], seed[1], 1'b0}, d);
    wt(380);
    rd(`OFS_OSC_STATUS, d);
    chk("hf stable", {4'h9, 1'b1, seed[0], seed[1], 1'b1}, d);
    wr(`OFS_OSC_AUX, 8'h00);
    wr(`OFS_OSC_CONTROL, 8'h38);
    hf_osc_running <= 1'b0;
    sec_osc_running <= 1'b0;
    wt(3);
    rd(`OFS_OSC_STATUS, d);
    chk("hf drop", {4'hA, 1'b0, seed[0], seed[1], 1'b0}, d);
    $display("test status done");
    results();
  end
endmodule
